// *** verilog/apc_pkg.sv ***
// Package: config word layout and decode codes for the voice path
package apc_pkg;
  localparam int CFG_W = 16;
  // Word indices as loaded by the host
  localparam logic [1:0] WORD0_IDX = 2'h0;
  localparam logic [1:0] WORD1_IDX = 2'h1;
  localparam logic [1:0] WORD2_IDX = 2'h2;
  // Reset values
  localparam logic [15:0] WORD0_RST = 16'h0000;
  localparam logic [15:0] WORD1_RST = 16'h0000;
  localparam logic [15:0] WORD2_RST = 16'h0000;
  // config_word_0 fields
  localparam int VOLUME_PD_BIT = 0;
  localparam int AMP_MODE_LSB = 1;
  localparam int OUT_MUX_LSB = 3;
  localparam int OSC_PD_BIT = 8;
  // config_word_1 fields
  localparam int LOWPASS_PD_BIT = 1;
  localparam int RATE_LSB = 2;
  localparam int FILT_IN_BIT = 4;
  localparam int SUM2_LSB = 5;
  localparam int VOL_LVL_LSB = 11;
  localparam int VOL_SRC_LSB = 14;
  // Two-bit codes, low bit is the lower data bit
  localparam logic [1:0] RATE_8K0 = 2'h0;
  localparam logic [1:0] RATE_6K4 = 2'h1;
  localparam logic [1:0] RATE_5K3 = 2'h2;
  localparam logic [1:0] SUM2_LPF_ONLY = 2'h2;
  localparam logic [1:0] VOLSRC_SUM2 = 2'h1;
  localparam logic [1:0] OUTMUX_VOLUME = 2'h0;
  localparam logic [1:0] OUTMUX_DAC = 2'h1;
  localparam logic [1:0] AMP_SPK_HIGH = 2'h1;
  // Attenuation in whole dB steps of 4 dB per count
  localparam logic [5:0] ATTEN_STEP_DB = 6'h04;
  // Sample rate selects
  typedef enum logic [1:0] {APC_RATE_8K0, APC_RATE_6K4, APC_RATE_5K3, APC_RATE_OTHER} apc_rate_t;
endpackage

// *** verilog/apc_word_reg.sv ***
// One configuration word register with load strobe
`timescale 1ns/100ps
module apc_word_reg
  import apc_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [15:0] data_i,
  output logic [15:0] word_o
);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      word_o <= RST_VAL;
    end else if (load_i) begin
      word_o <= data_i;
    end
  end
endmodule

// *** verilog/apc_decoder.sv ***
// Top: config word storage and voice path select decode
`timescale 1ns/100ps
module apc_decoder
  import apc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_rise_i,
  input wire logic load_i,
  input wire logic [1:0] word_sel_i,
  input wire logic [15:0] word_data_i,
  output logic [15:0] config_word_0_o,
  output logic [15:0] config_word_1_o,
  output logic [15:0] config_word_2_o,
  output logic filter_from_array_o,
  output logic lowpass_power_o,
  output logic [1:0] sample_rate_o,
  output logic sum2_lpf_only_o,
  output logic volume_from_sum2_o,
  output logic volume_power_o,
  output logic [2:0] volume_level_o,
  output logic [5:0] atten_db_o,
  output logic out_from_volume_o,
  output logic out_from_dac_o,
  output logic speaker_high_gain_o,
  output logic aux_out_power_o,
  output logic osc_power_o,
  output logic playback_chain_o
);
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;
  logic ld0;
  logic ld1;
  logic ld2;
  logic [1:0] rate_code;
  logic [1:0] sum2_code;
  logic [1:0] volsrc_code;
  logic [1:0] outmux_code;
  logic [1:0] amp_code;
  logic [2:0] vol_lvl;
  logic [1:0] next_rate;

  // Words are applied on the serial clock rising edge only
  wire load_ok = load_i & scl_rise_i;
  assign ld0 = load_ok && (word_sel_i == WORD0_IDX);
  assign ld1 = load_ok && (word_sel_i == WORD1_IDX);
  assign ld2 = load_ok && (word_sel_i == WORD2_IDX);

  apc_word_reg #(.RST_VAL(WORD0_RST)) u_w0 (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_i(ld0), .data_i(word_data_i), .word_o(w0));
  apc_word_reg #(.RST_VAL(WORD1_RST)) u_w1 (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_i(ld1), .data_i(word_data_i), .word_o(w1));
  apc_word_reg #(.RST_VAL(WORD2_RST)) u_w2 (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_i(ld2), .data_i(word_data_i), .word_o(w2));

  assign rate_code = w1[RATE_LSB +: 2];
  assign sum2_code = w1[SUM2_LSB +: 2];
  assign volsrc_code = w1[VOL_SRC_LSB +: 2];
  assign vol_lvl = w1[VOL_LVL_LSB +: 3];
  assign outmux_code = w0[OUT_MUX_LSB +: 2];
  assign amp_code = w0[AMP_MODE_LSB +: 2];

  function automatic logic [1:0] rate_dec(input logic [1:0] c);
    if (c == RATE_8K0) rate_dec = APC_RATE_8K0;
    else if (c == RATE_6K4) rate_dec = APC_RATE_6K4;
    else if (c == RATE_5K3) rate_dec = APC_RATE_5K3;
    else rate_dec = APC_RATE_OTHER;
  endfunction
  assign next_rate = rate_dec(rate_code);

  // Registered outputs keep glitches off the analog selects
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      filter_from_array_o <= 1'b0;
      lowpass_power_o <= 1'b0;
      sample_rate_o <= 2'h0;
      sum2_lpf_only_o <= 1'b0;
      volume_from_sum2_o <= 1'b0;
      volume_power_o <= 1'b0;
      volume_level_o <= 3'h0;
      atten_db_o <= 6'h00;
      out_from_volume_o <= 1'b0;
      out_from_dac_o <= 1'b0;
      speaker_high_gain_o <= 1'b0;
      aux_out_power_o <= 1'b0;
      osc_power_o <= 1'b0;
      playback_chain_o <= 1'b0;
    end else begin
      filter_from_array_o <= w1[FILT_IN_BIT];
      lowpass_power_o <= ~w1[LOWPASS_PD_BIT];
      sample_rate_o <= next_rate;
      sum2_lpf_only_o <= (sum2_code == SUM2_LPF_ONLY);
      volume_from_sum2_o <= (volsrc_code == VOLSRC_SUM2);
      volume_power_o <= ~w0[VOLUME_PD_BIT];
      osc_power_o <= ~w0[OSC_PD_BIT];
      // binary level, 4 dB per count
      volume_level_o <= vol_lvl;
      atten_db_o <= 6'({3'h0, vol_lvl} * ATTEN_STEP_DB);
      out_from_volume_o <= (outmux_code == OUTMUX_VOLUME);
      out_from_dac_o <= (outmux_code == OUTMUX_DAC);
      speaker_high_gain_o <= (amp_code == AMP_SPK_HIGH);
      aux_out_power_o <= (amp_code != AMP_SPK_HIGH);
      playback_chain_o <= w1[FILT_IN_BIT] & ~w1[LOWPASS_PD_BIT]
        & (sum2_code == SUM2_LPF_ONLY) & (volsrc_code == VOLSRC_SUM2)
        & ~w0[VOLUME_PD_BIT] & (outmux_code == OUTMUX_VOLUME);
    end
  end

  assign config_word_0_o = w0;
  assign config_word_1_o = w1;
  assign config_word_2_o = w2;

  // level 011 maps to 12 dB
  a_atten_twelve: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (vol_lvl == 3'h3) |=> (atten_db_o == 6'h0C))
    else $error("level 3 not 12 dB");
  a_atten_binary: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 (atten_db_o == 6'({3'h0, volume_level_o} * ATTEN_STEP_DB)))
    else $error("attenuation not binary");
  a_filter_src: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(w1[FILT_IN_BIT]) |=> filter_from_array_o)
    else $error("filter input not array");
  a_lpf_power: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !w1[LOWPASS_PD_BIT]) |=> lowpass_power_o)
    else $error("lowpass not powered");
  a_rate_8k: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rate_code == 2'h0) |=> (sample_rate_o == APC_RATE_8K0))
    else $error("rate not 8 kHz");
  a_rate_6k4: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rate_code == 2'h1) |=> (sample_rate_o == APC_RATE_6K4))
    else $error("rate not 6.4 kHz");
  a_rate_5k3: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rate_code == 2'h2) |=> (sample_rate_o == APC_RATE_5K3))
    else $error("rate not 5.3 kHz");
  a_sum2_lpf: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (w1[6:5] == 2'h2) |=> sum2_lpf_only_o)
    else $error("sum2 not lowpass only");
  a_vol_src: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (w1[15:14] == 2'h1) |=> volume_from_sum2_o)
    else $error("volume mux not sum2");
  a_vol_power: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !w0[0]) |=> volume_power_o)
    else $error("attenuator not powered");
  a_out_mux: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 !(out_from_volume_o && out_from_dac_o))
    else $error("output mux both selected");
  a_dac_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (w0[4:3] == 2'h1) |=> out_from_dac_o)
    else $error("output mux not dac");
  a_amp_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (w0[2:1] == 2'h1) |=> (speaker_high_gain_o && !aux_out_power_o))
    else $error("amp mode wrong");
  a_osc_power: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !w0[8]) |=> osc_power_o)
    else $error("oscillator not powered");
  a_chain_play: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (w0 == 16'h2422 && w1 == 16'h59D1) |=> playback_chain_o)
    else $error("playback chain not set");
  a_word_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ld1 |=> $stable(w1))
    else $error("word 1 changed without load");
  c_playback: cover property (@(posedge clk_i) disable iff (sys_rst_i) playback_chain_o);
  c_dac_path: cover property (@(posedge clk_i) disable iff (sys_rst_i) out_from_dac_o);
  c_rate_5k3: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    sample_rate_o == APC_RATE_5K3);
endmodule

// *** testbench/apc_host.sv ***
// Host model that loads configuration words on serial clock edges
`timescale 1ns/100ps
module apc_host (
  input wire logic clk_i,
  output logic scl_rise_o,
  output logic load_o,
  output logic [1:0] word_sel_o,
  output logic [15:0] word_data_o
);
  initial begin
    scl_rise_o = 1'b0;
    load_o = 1'b0;
    word_sel_o = 2'h0;
    word_data_o = 16'h0000;
  end
  task automatic send(input logic [1:0] sel, input logic [15:0] data, input logic edge_ok);
    @(posedge clk_i);
    scl_rise_o <= edge_ok;
    load_o <= 1'b1;
    word_sel_o <= sel;
    word_data_o <= data;
    @(posedge clk_i);
    scl_rise_o <= 1'b0;
    load_o <= 1'b0;
    // Scrambled after release so a stale word never looks valid
    word_data_o <= ~data;
  endtask
  // playback words, order 0, 1, 2
  task automatic playback();
    send(2'h0, 16'h2422, 1'b1);
    send(2'h1, 16'h59D1, 1'b1);
    send(2'h2, 16'h0003, 1'b1);
  endtask
endmodule

// *** testbench/tb.sv ***
// Testbench for the voice path config decoder
`timescale 1ns/100ps
module tb;
  import apc_pkg::*;
  logic clk_i, sys_rst_i, scl_rise, load, vol_pw, osc_pw, chain;
  logic [1:0] sel, rate;
  logic [15:0] data, w0, w1, w2;
  logic f_arr, lp_pw, s2, v_s2, o_vol, o_dac, hi_g, aux_pw;
  logic [2:0] lvl;
  logic [5:0] atten;
  int n_fail = 0;
  int samples_checked = 0;
  apc_host host (.clk_i(clk_i), .scl_rise_o(scl_rise), .load_o(load), .word_sel_o(sel),
    .word_data_o(data));
  apc_decoder DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_rise_i(scl_rise), .load_i(load),
    .word_sel_i(sel), .word_data_i(data), .config_word_0_o(w0), .config_word_1_o(w1),
    .config_word_2_o(w2), .filter_from_array_o(f_arr), .lowpass_power_o(lp_pw),
    .sample_rate_o(rate), .sum2_lpf_only_o(s2), .volume_from_sum2_o(v_s2),
    .volume_power_o(vol_pw), .volume_level_o(lvl), .atten_db_o(atten),
    .out_from_volume_o(o_vol), .out_from_dac_o(o_dac), .speaker_high_gain_o(hi_g),
    .aux_out_power_o(aux_pw), .osc_power_o(osc_pw), .playback_chain_o(chain));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Decoded outputs land one edge after the load is taken
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic t_playback();
    host.playback();
    settle();
    chk(w0, 16'h2422);
    chk(w1, 16'h59D1);
    chk(w2, 16'h0003);
    chk(f_arr, 1'b1);
    chk(lp_pw, 1'b1);
    chk(rate, APC_RATE_8K0);
    chk(s2, 1'b1);
    chk(v_s2, 1'b1);
    chk(vol_pw, 1'b1);
    chk(atten, 6'h0C);
    chk(o_vol, 1'b1);
    chk({hi_g, aux_pw}, 2'h2);
    chk(osc_pw, 1'b1);
    chk(chain, 1'b1);
  endtask
  task automatic t_rates();
    for (int i = 0; i < 4; i++) begin
      host.send(2'h1, 16'h59D1 | 16'(i << 2), 1'b1);
      settle();
      chk(rate, 16'(i));
    end
  endtask
  task automatic t_volume();
    for (int i = 0; i < 8; i++) begin
      host.send(2'h1, 16'h41D1 | 16'(i << 11), 1'b1);
      settle();
      chk(lvl, 16'(i));
      chk(atten, 16'(i * 4));
    end
  endtask
  task automatic t_word0();
    host.send(2'h0, 16'h010D, 1'b1);
    settle();
    chk(vol_pw, 1'b0);
    chk({o_dac, o_vol}, 2'h2);
    chk({hi_g, aux_pw}, 2'h1);
    chk(osc_pw, 1'b0);
    chk(chain, 1'b0);
  endtask
  task automatic t_refuse();
    host.send(2'h0, 16'h2422, 1'b0);
    host.send(2'h3, 16'hFFFF, 1'b1);
    settle();
    chk(w0, 16'h010D);
    chk(w1, 16'h79D1);
    chk(o_dac, 1'b1);
  endtask
  // Path selects must also drop when their bits clear, and filter power when its power-down bit sets
  task automatic t_word1_off();
    host.send(2'h1, 16'h0002, 1'b1);
    settle();
    chk(w1, 16'h0002);
    chk(f_arr, 1'b0);
    chk(lp_pw, 1'b0);
    chk(s2, 1'b0);
    chk(v_s2, 1'b0);
    chk(chain, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    sys_rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(w0, WORD0_RST);
    t_playback();
    t_rates();
    t_volume();
    t_word0();
    t_refuse();
    t_word1_off();
    report_and_stop();
  end
endmodule
